// ### inc/standby_pkg.sv
package standby_pkg;

    // Oscillation stabilization wait after deep-sleep release on crystal source
    localparam int unsigned STAB_WAIT_US     = 102;
    localparam int unsigned CLOCK_MHZ        = 25;
    localparam int unsigned STAB_WAIT_CYCLES = STAB_WAIT_US * CLOCK_MHZ;
    localparam int          STAB_WIDTH       = 12;
    localparam logic [11:0] STAB_LAST        = 12'(STAB_WAIT_CYCLES - 1);
    localparam logic [11:0] STAB_ZERO        = 12'h000;

    typedef enum logic [2:0] {
        RUN,
        LIGHT_SLEEP,
        DEEP_SLEEP,
        STAB_WAIT,
        PERIPH_WAKE
    } standby_state_type;

endpackage

// ### inc/stab_if.sv
`timescale 1ns/10ps
interface stab_if;
    logic start;
    logic done;
    modport ctrl  (output start, input done);
    modport timer (input start, output done);
endinterface

// ### hdl/stab_timer.sv
`timescale 1ns/10ps
module stab_timer
    import standby_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    stab_if.timer     link
);
    logic [11:0] count;
    logic [11:0] next_count;
    logic        busy;
    logic        next_busy;
    logic        done_q;
    logic        next_done_q;

    always_comb begin
        next_count  = count;
        next_busy   = busy;
        next_done_q = 1'b0;
        if (link.start) begin
            next_count = STAB_LAST;
            next_busy  = 1'b1;
        end else if (busy) begin
            if (count == STAB_ZERO) begin
                next_busy   = 1'b0;
                next_done_q = 1'b1;
            end else begin
                next_count = count - 12'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count  <= STAB_ZERO;
            busy   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count  <= next_count;
            busy   <= next_busy;
            done_q <= next_done_q;
        end
    end

    assign link.done = done_q;
endmodule

// ### hdl/standby_control.sv
`timescale 1ns/10ps
module standby_control
    import standby_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic light_sleep_instr,
    input  wire logic deep_sleep_instr,
    input  wire logic irq_request,
    input  wire logic periph_wake_enable,
    input  wire logic onchip_osc_selected,
    input  wire logic crystal_clock_source,
    input  wire logic gate_driver_serial_channel,
    input  wire logic async_serial_channel,
    input  wire logic calendar_periodic_irq,
    input  wire logic interval_timer_irq,
    input  wire logic event_link_input,
    input  wire logic transfer_controller,
    input  wire logic periph_op_done,
    input  wire logic osc_was_running,
    output logic      cpu_clock_enable,
    output logic      highspeed_osc_enable,
    output logic      cpu_peripheral_clock_enable,
    output logic      periph_wake_active,
    output logic      hold_state,
    output logic      port_latch_hold,
    output logic      in_light_sleep,
    output logic      in_deep_sleep
);
    standby_state_type state;
    standby_state_type next_state;
    logic              next_cpu_clock_enable;
    logic              next_highspeed_osc_enable;
    logic              next_cpu_peripheral_clock_enable;
    logic              next_periph_wake_active;
    logic              next_hold_state;
    logic              xtal_at_entry;
    logic              next_xtal_at_entry;
    logic              snooze_ok;
    logic              next_snooze_ok;
    logic              next_port_latch_hold;
    logic              next_in_light_sleep;
    logic              next_in_deep_sleep;

    // Settling count lives in its own timer so the state machine stays small
    stab_if stab ();

    stab_timer u_stab (
        .clock (clock),
        .rst_n (rst_n),
        .link  (stab.timer)
    );

    function automatic logic wake_source(input logic serial_a, input logic serial_b,
                                         input logic rtc, input logic itv,
                                         input logic evt, input logic xfer);
        return serial_a | serial_b | rtc | itv | evt | xfer;
    endfunction

    logic deep_entry;
    assign deep_entry = (state == RUN) && deep_sleep_instr;

    // Any armed peripheral source may start snooze work
    logic periph_trigger;
    assign periph_trigger = wake_source(gate_driver_serial_channel, async_serial_channel,
                                        calendar_periodic_irq, interval_timer_irq,
                                        event_link_input, transfer_controller);

    always_comb begin
        next_state = state;
        stab.start = 1'b0;
        unique case (state)
            RUN: begin
                if (deep_sleep_instr) begin
                    next_state = DEEP_SLEEP;
                end else if (light_sleep_instr) begin
                    next_state = LIGHT_SLEEP;
                end
            end
            LIGHT_SLEEP: begin
                // Oscillator runs only if osc_was_running; return to RUN with no settling wait
                if (irq_request) begin
                    next_state = RUN;
                end
            end
            DEEP_SLEEP: begin
                // Crystal must settle first; the on-chip source restarts at once
                if (irq_request) begin
                    if (xtal_at_entry) begin
                        next_state = STAB_WAIT;
                        stab.start = 1'b1;
                    end else begin
                        next_state = RUN;
                    end
                end else if (snooze_ok && periph_trigger) begin
                    next_state = PERIPH_WAKE;
                end
            end
            STAB_WAIT: begin
                // Held here until the timer reports the oscillator settled
                if (stab.done) begin
                    next_state = RUN;
                end
            end
            PERIPH_WAKE: begin
                // Interrupt raised by the peripheral work takes precedence
                if (irq_request) begin
                    next_state = RUN;
                end else if (periph_op_done) begin
                    next_state = DEEP_SLEEP;
                end
            end
            default: next_state = RUN;
        endcase
    end

    always_comb begin
        next_cpu_clock_enable            = 1'b0;
        next_highspeed_osc_enable        = 1'b0;
        next_cpu_peripheral_clock_enable = 1'b0;
        next_periph_wake_active          = 1'b0;
        // Anything but RUN freezes registers, flags and port latches
        next_hold_state                  = 1'b1;
        next_port_latch_hold             = 1'b1;
        next_in_light_sleep              = 1'b0;
        next_in_deep_sleep               = 1'b0;
        unique case (next_state)
            RUN: begin
                next_cpu_clock_enable            = 1'b1;
                next_highspeed_osc_enable        = 1'b1;
                next_cpu_peripheral_clock_enable = 1'b1;
                next_hold_state                  = 1'b0;
                next_port_latch_hold             = 1'b0;
            end
            LIGHT_SLEEP: begin
                // CPU and peripheral clocks are gated; oscillator keeps pre-entry state
                next_highspeed_osc_enable = osc_was_running;
                next_in_light_sleep       = 1'b1;
            end
            DEEP_SLEEP: begin
                // Both high-speed oscillators off: nothing is clocked
                next_in_deep_sleep = 1'b1;
            end
            STAB_WAIT: begin
                // Oscillator settles with the CPU still held off
                next_highspeed_osc_enable = 1'b1;
            end
            PERIPH_WAKE: begin
                // Peripherals clocked, CPU clock stays gated
                next_highspeed_osc_enable        = 1'b1;
                next_cpu_peripheral_clock_enable = 1'b1;
                next_periph_wake_active          = 1'b1;
            end
        endcase
    end

    // Clock-source facts frozen at deep entry, so a later source change
    // cannot retarget a wake already under way
    always_comb begin
        next_xtal_at_entry = xtal_at_entry;
        next_snooze_ok     = snooze_ok;
        if (deep_entry) begin
            next_xtal_at_entry = crystal_clock_source;
            // Snooze is only honoured on the on-chip oscillator
            next_snooze_ok     = periph_wake_enable & onchip_osc_selected;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xtal_at_entry <= 1'b0;
            snooze_ok     <= 1'b0;
        end else begin
            xtal_at_entry <= next_xtal_at_entry;
            snooze_ok     <= next_snooze_ok;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clock_enable            <= 1'b1;
            highspeed_osc_enable        <= 1'b1;
            cpu_peripheral_clock_enable <= 1'b1;
            periph_wake_active          <= 1'b0;
            hold_state                  <= 1'b0;
            port_latch_hold             <= 1'b0;
            in_light_sleep              <= 1'b0;
            in_deep_sleep               <= 1'b0;
        end else begin
            cpu_clock_enable            <= next_cpu_clock_enable;
            highspeed_osc_enable        <= next_highspeed_osc_enable;
            cpu_peripheral_clock_enable <= next_cpu_peripheral_clock_enable;
            periph_wake_active          <= next_periph_wake_active;
            hold_state                  <= next_hold_state;
            port_latch_hold             <= next_port_latch_hold;
            in_light_sleep              <= next_in_light_sleep;
            in_deep_sleep               <= next_in_deep_sleep;
        end
    end
endmodule

// ### bench/standby_control_chk.sv
`timescale 1ns/10ps
module standby_control_chk
    import standby_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic light_sleep_instr,
    input wire logic deep_sleep_instr,
    input wire logic irq_request,
    input wire logic crystal_clock_source,
    input wire logic periph_op_done,
    input wire logic osc_was_running,
    input wire logic cpu_clock_enable,
    input wire logic highspeed_osc_enable,
    input wire logic cpu_peripheral_clock_enable,
    input wire logic periph_wake_active,
    input wire logic hold_state,
    input wire logic port_latch_hold,
    input wire logic in_light_sleep,
    input wire logic in_deep_sleep
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Settling wait is far too long for a delay range: counted here instead
    localparam int unsigned STAB_SLACK = 8;
    logic        xtal_seen;
    int unsigned stab_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xtal_seen <= 1'b0;
            stab_cnt  <= 0;
        end else begin
            if (cpu_clock_enable && deep_sleep_instr) begin
                xtal_seen <= crystal_clock_source;
            end
            if (in_deep_sleep && irq_request && xtal_seen) begin
                stab_cnt <= 1;
            end else if (stab_cnt != 0 && !cpu_clock_enable) begin
                stab_cnt <= stab_cnt + 1;
            end else begin
                stab_cnt <= 0;
            end
        end
    end
    chk_light_entry: assert property (cpu_clock_enable && light_sleep_instr
        && !deep_sleep_instr |=> in_light_sleep && !cpu_clock_enable) else $error("light entry");
    chk_light_osc: assert property (in_light_sleep && $stable(osc_was_running)
        |-> highspeed_osc_enable == osc_was_running) else $error("light osc");
    chk_light_exit: assert property (in_light_sleep && irq_request
        |=> cpu_clock_enable) else $error("light exit");
    chk_deep_entry: assert property (cpu_clock_enable && deep_sleep_instr
        |=> in_deep_sleep) else $error("deep entry");
    chk_deep_osc_off: assert property (in_deep_sleep
        |-> !highspeed_osc_enable && !cpu_clock_enable) else $error("deep osc");
    chk_deep_release: assert property (in_deep_sleep && irq_request
        |=> !in_deep_sleep) else $error("deep release");
    chk_stab_wait: assert property (stab_cnt != 0 && cpu_clock_enable
        |-> stab_cnt >= STAB_WAIT_CYCLES) else $error("stab wait");
    chk_stab_bound: assert property (stab_cnt <= STAB_WAIT_CYCLES + STAB_SLACK)
        else $error("stab bound");
    chk_wake_no_cpu: assert property (periph_wake_active
        |-> !cpu_clock_enable && cpu_peripheral_clock_enable) else $error("wake cpu");
    chk_wake_return: assert property (periph_wake_active && periph_op_done && !irq_request
        |=> in_deep_sleep) else $error("wake return");
    chk_state_hold: assert property (!cpu_clock_enable
        |-> hold_state && port_latch_hold) else $error("hold");
    cover property (in_light_sleep ##1 cpu_clock_enable);
    cover property (periph_wake_active ##1 in_deep_sleep);
    cover property (in_deep_sleep && irq_request && crystal_clock_source);
endmodule
bind standby_control standby_control_chk chk (.*);

// ### bench/wake_source_model.sv
`timescale 1ns/10ps
module wake_source_model (
    input  wire logic       clock,
    input  wire logic       fire,
    input  wire logic [2:0] sel,
    input  wire logic [1:0] lag,
    output logic      [5:0] trig
);
    logic [1:0] cnt;
    logic       busy;
    initial begin
        trig = '0;
        busy = 1'b0;
        cnt  = '0;
    end
    // Prompt or slow source: one-cycle request lag+1 cycles after fire is sampled
    always @(posedge clock) begin
        trig <= '0;
        if (fire) begin
            busy <= 1'b1;
            cnt  <= lag;
        end else if (busy && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (busy) begin
            busy <= 1'b0;
            trig <= 6'h01 << sel;
        end
    end
endmodule

// ### bench/standby_control_bench.sv
`timescale 1ns/10ps
`define CMP(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module standby_control_bench;
    logic clock, rst_n, light_sleep_instr, deep_sleep_instr, irq_request, fire;
    logic periph_wake_enable, onchip_osc_selected, crystal_clock_source, periph_op_done;
    logic osc_was_running, gate_driver_serial_channel, async_serial_channel;
    logic calendar_periodic_irq, interval_timer_irq, event_link_input, transfer_controller;
    logic cpu_clock_enable, highspeed_osc_enable, cpu_peripheral_clock_enable;
    logic periph_wake_active, hold_state, port_latch_hold, in_light_sleep, in_deep_sleep;
    logic [2:0]  sel;
    logic [1:0]  lag;
    logic [4:0]  pul;
    logic [5:0]  trig;
    logic [7:0]  st, prev, exp_v;
    logic [31:0] rnd;
    logic [7:0]  q[$];
    int          n_mismatch, tests_run;
    // Flags: hold, latch, cpu, osc, periph clock, wake, light, deep; FF never occurs
    localparam logic [7:0] RUN_V = 8'h38, DEEP_V = 8'hC1, STAB_V = 8'hD0;
    localparam logic [7:0] WAKE_V = 8'hDC, NONE = 8'hFF;
    assign {fire, periph_op_done, irq_request, deep_sleep_instr, light_sleep_instr} = pul;
    assign {transfer_controller, event_link_input, interval_timer_irq, calendar_periodic_irq,
        async_serial_channel, gate_driver_serial_channel} = trig;
    assign st = {hold_state, port_latch_hold, cpu_clock_enable, highspeed_osc_enable,
        cpu_peripheral_clock_enable, periph_wake_active, in_light_sleep, in_deep_sleep};
    standby_control dut (.*);
    wake_source_model src (.clock, .fire, .sel, .lag, .trig);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_sim;
        // An expected change that never came counts as a mismatch
        if (q.size() != 0) begin
            n_mismatch++;
        end
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Pulse one request, note expected flag changes, wait bounded for them
    task automatic act(input int i, input logic [7:0] e, input logic [7:0] e2);
        @(posedge clock);
        pul[i] <= 1'b1;
        @(posedge clock);
        pul[i] <= 1'b0;
        if (e != NONE) q.push_back(e);
        if (e2 != NONE) q.push_back(e2);
        repeat (3000) if (q.size() != 0) @(posedge clock);
        repeat (6) @(posedge clock);
    endtask
    always @(negedge clock) begin
        if (rst_n === 1'b1 && st !== prev) begin
            exp_v = (q.size() != 0) ? q.pop_front() : ~st;
            `CMP(st, exp_v)
        end
        prev = st;
    end
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (10000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end
    initial begin
        {rst_n, pul, periph_wake_enable, onchip_osc_selected} = '0;
        {crystal_clock_source, osc_was_running, sel, lag} = '0;
        rnd = 32'h0099;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            osc_was_running <= rnd[0];
            act(0, {3'b110, rnd[0], 4'h2}, NONE);
            act(2, RUN_V, NONE);
        end
        act(1, DEEP_V, NONE);
        act(4, NONE, NONE);
        act(0, NONE, NONE);
        act(2, RUN_V, NONE);
        crystal_clock_source <= 1'b1;
        act(1, DEEP_V, NONE);
        act(2, STAB_V, RUN_V);
        crystal_clock_source <= 1'b0;
        periph_wake_enable <= 1'b1;
        onchip_osc_selected <= 1'b1;
        act(1, DEEP_V, NONE);
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            sel <= 3'(k);
            lag <= rnd[1:0];
            act(4, WAKE_V, NONE);
            act(3, DEEP_V, NONE);
        end
        act(2, RUN_V, NONE);
        onchip_osc_selected <= 1'b0;
        act(1, DEEP_V, NONE);
        act(4, NONE, NONE);
        act(2, RUN_V, NONE);
        onchip_osc_selected <= 1'b1;
        act(1, DEEP_V, NONE);
        act(4, WAKE_V, NONE);
        act(2, RUN_V, NONE);
        end_sim();
    end
endmodule
